// ### hdl/sfifo_pkg.sv
// Shared constants and types of the slave FIFO port
`default_nettype none
package sfifo_pkg;
   localparam int DATA_W = 16;
   localparam int THREADS = 4;
   localparam int THREAD_W = 2;
   localparam int ADDR_W = 5;
   localparam int FIFO_DEPTH = 4;
   localparam int LVL_W = 3;
   localparam logic [LVL_W-1:0] FULL_LEVEL = 3'h4;
   localparam logic [LVL_W-1:0] PARTIAL_LEVEL = 3'h2;
   localparam int CLK_PERIOD_NS = 50;
   // Socket switching delay in clock cycles, anywhere from 2 to 68
   localparam int SOCKET_SWITCH_CYCLES = 8;
   // Counter runs down to zero and one more edge returns to ready
   localparam logic [6:0] SOCKET_SWITCH_LOAD = 7'(SOCKET_SWITCH_CYCLES - 1);

   typedef enum logic [1:0] {FLAG_EMPTY, FLAG_FULL, FLAG_PARTIAL} flag_kind_e;
   typedef enum logic {SW_READY, SW_WAIT} sw_state_e;

   typedef struct packed {
      logic [1:0] cs_sy;
      logic [1:0] rd_sy;
      logic [1:0] wr_sy;
      logic [1:0] pk_sy;
      logic [1:0] oe_sy;
      logic [1:0] sw_sy;
      logic [1:0][ADDR_W-1:0] sel_sy;
      logic [1:0][DATA_W-1:0] dat_sy;
      logic rd_prev;
      logic wr_prev;
      logic pk_prev;
      logic sw_prev;
      logic [DATA_W-1:0] d_hold;
      logic pk_hold;
      logic [THREAD_W-1:0] cur_thread;
      logic [DATA_W-1:0] data_p1;
      logic [DATA_W-1:0] data_out;
      logic oe_n;
      logic [1:0] flag_p1;
      logic [1:0] flag_out;
      sw_state_e sw_state;
      logic [6:0] sw_cnt;
      logic [THREAD_W-1:0] socket;
      logic atr;
      logic hold_v;
      logic [THREAD_W-1:0] hold_t;
      logic [DATA_W-1:0] hold_d;
      logic tx_ready;
      logic rx_v;
      logic rx_last;
      logic [THREAD_W-1:0] rx_t;
      logic [DATA_W-1:0] rx_d;
      logic zlp_v;
      logic [THREAD_W-1:0] zlp_t;
   } port_state_s;

   localparam port_state_s PORT_RESET = '{
      cs_sy: 2'h3, rd_sy: 2'h3, wr_sy: 2'h3, pk_sy: 2'h3, oe_sy: 2'h3, sw_sy: 2'h3,
      rd_prev: 1'h1, wr_prev: 1'h1, pk_prev: 1'h1, sw_prev: 1'h1, oe_n: 1'h1,
      sw_state: SW_READY, default: '0};
endpackage
`default_nettype wire

// ### hdl/word_fifo.sv
// Word FIFO with valid/ready on both sides and a fill level
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready,
   // Fill level
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] wr_ptr;
      logic [PTR_W-1:0] rd_ptr;
      logic [CNT_W-1:0] count;
   } fifo_state_s;

   fifo_state_s s_reg;
   fifo_state_s s_next;
   logic push;
   logic pop;

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready = (s_reg.count != CNT_W'(DEPTH));
   assign out_valid = (s_reg.count != '0);
   assign out_data = s_reg.mem[s_reg.rd_ptr];
   assign level = s_reg.count;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      s_next = s_reg;
      if (push)
      begin
         s_next.mem[s_reg.wr_ptr] = in_data;
         s_next.wr_ptr = ptr_inc(s_reg.wr_ptr);
      end
      if (pop)
         s_next.rd_ptr = ptr_inc(s_reg.rd_ptr);
      case ({push, pop})
         2'b10: s_next.count = s_reg.count + 1'b1;
         2'b01: s_next.count = s_reg.count - 1'b1;
         default: s_next.count = s_reg.count;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end
endmodule
`default_nettype wire

// ### hdl/slave_fifo_port.sv
// Slave FIFO parallel port: master pins, per-thread FIFOs, flags, core streams
`default_nettype none
module slave_fifo_port
   import sfifo_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Mode straps
   input wire logic sync_mode,
   input wire logic addr_5bit_mode,
   input wire logic [THREADS-1:0] thread_is_producer,
   // Flag configuration
   input wire logic [1:0] flag_a_kind,
   input wire logic flag_a_current,
   input wire logic [THREAD_W-1:0] flag_a_thread,
   input wire logic [1:0] flag_b_kind,
   input wire logic flag_b_current,
   input wire logic [THREAD_W-1:0] flag_b_thread,
   // Master pins
   input wire logic fifo_select_n,
   input wire logic bus_drive_enable_n,
   input wire logic fifo_read_strobe_n,
   input wire logic fifo_write_strobe_n,
   input wire logic packet_commit_n,
   input wire logic socket_change_strobe_n,
   input wire logic [ADDR_W-1:0] fifo_select_lines,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe_n,
   output logic flag_a,
   output logic flag_b,
   output logic active_thread_ready,
   // Core stream into consumer threads
   input wire logic core_tx_valid,
   input wire logic [THREAD_W-1:0] core_tx_thread,
   input wire logic [DATA_W-1:0] core_tx_data,
   output logic core_tx_ready,
   // Core stream out of producer threads
   input wire logic [THREAD_W-1:0] core_rx_pick,
   input wire logic core_rx_ready,
   output logic core_rx_valid,
   output logic [THREAD_W-1:0] core_rx_thread,
   output logic [DATA_W-1:0] core_rx_data,
   output logic core_rx_last,
   output logic zlp_valid,
   output logic [THREAD_W-1:0] zlp_thread
);
   localparam int SSD_LO = 2;
   localparam int SSD_HI = 68;

   port_state_s s_reg;
   port_state_s s_next;

   logic [THREADS-1:0] f_in_valid;
   logic [THREADS-1:0] f_in_ready;
   logic [THREADS-1:0] f_out_valid;
   logic [THREADS-1:0] f_out_ready;
   logic [THREADS-1:0][DATA_W:0] f_in_data;
   logic [THREADS-1:0][DATA_W:0] f_out_data;
   logic [THREADS-1:0][LVL_W-1:0] f_level;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin view: in synchronous mode the master shares core_clk, so pins are used
   // as sampled; in asynchronous mode only the second synchroniser stage is read.
   // Async strobes must stay in each state for at least two core clocks.
   wire logic cs_e = sync_mode ? fifo_select_n : s_reg.cs_sy[1];
   wire logic rd_e = sync_mode ? fifo_read_strobe_n : s_reg.rd_sy[1];
   wire logic wr_e = sync_mode ? fifo_write_strobe_n : s_reg.wr_sy[1];
   wire logic pk_e = sync_mode ? packet_commit_n : s_reg.pk_sy[1];
   wire logic oe_e = sync_mode ? bus_drive_enable_n : s_reg.oe_sy[1];
   wire logic sw_e = sync_mode ? socket_change_strobe_n : s_reg.sw_sy[1];
   wire logic [ADDR_W-1:0] sel_e = sync_mode ? fifo_select_lines : s_reg.sel_sy[1];

   // Pointer events
   wire logic pop_ev = !cs_e && (sync_mode ? !rd_e : (rd_e && !s_reg.rd_prev));
   wire logic push_ev = !cs_e && (sync_mode ? !wr_e : (wr_e && !s_reg.wr_prev));
   // Async data is taken from the last sample with the strobe still low,
   // since the hold time after the rising strobe is far below one clock
   wire logic [DATA_W-1:0] push_data = sync_mode ? data_in : s_reg.d_hold;
   wire logic push_last = sync_mode ? !pk_e : s_reg.pk_hold;
   wire logic zlp_ev = !cs_e && !pk_e && s_reg.pk_prev && wr_e;
   wire logic sw_accept = addr_5bit_mode && !cs_e && !sw_e && s_reg.sw_prev &&
      (s_reg.sw_state == SW_READY);
   wire logic rx_take = !s_reg.rx_v || core_rx_ready;
   wire logic [DATA_W-1:0] head_cur = f_out_data[s_reg.cur_thread][DATA_W-1:0];
   wire logic [LVL_W-1:0] level_cur = f_level[s_reg.cur_thread];

   function automatic logic flag_eval(input logic [1:0] kind, input logic current,
      input logic [THREAD_W-1:0] fixed);
      logic [LVL_W-1:0] lv;
      lv = f_level[current ? s_reg.cur_thread : fixed];
      case (flag_kind_e'(kind))
         FLAG_EMPTY: flag_eval = (lv == '0);
         FLAG_FULL: flag_eval = (lv == FULL_LEVEL);
         FLAG_PARTIAL: flag_eval = (lv >= PARTIAL_LEVEL);
         default: flag_eval = 1'b0;
      endcase
   endfunction

   wire logic [1:0] flag_raw = {flag_eval(flag_b_kind, flag_b_current, flag_b_thread),
      flag_eval(flag_a_kind, flag_a_current, flag_a_thread)};

   ////////////////////////////////////////////////////////////////////////////////
   // Per-thread FIFOs: producers fill from the pins, consumers from the core
   for (genvar j = 0; j < THREADS; j++)
   begin : g_thr
      assign f_in_valid[j] = thread_is_producer[j] ?
         (push_ev && s_reg.cur_thread == THREAD_W'(j)) :
         (s_reg.hold_v && s_reg.hold_t == THREAD_W'(j));
      assign f_in_data[j] = thread_is_producer[j] ? {push_last, push_data} :
         {1'b0, s_reg.hold_d};
      assign f_out_ready[j] = thread_is_producer[j] ?
         (rx_take && core_rx_pick == THREAD_W'(j)) :
         (pop_ev && s_reg.cur_thread == THREAD_W'(j));

      word_fifo #(
         .WIDTH(DATA_W + 1),
         .DEPTH(FIFO_DEPTH)
      ) u_fifo (
         .core_clk(core_clk),
         .nrst(nrst),
         .in_valid(f_in_valid[j]),
         .in_data(f_in_data[j]),
         .in_ready(f_in_ready[j]),
         .out_valid(f_out_valid[j]),
         .out_data(f_out_data[j]),
         .out_ready(f_out_ready[j]),
         .level(f_level[j])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      s_next = s_reg;
      s_next.cs_sy = {s_reg.cs_sy[0], fifo_select_n};
      s_next.rd_sy = {s_reg.rd_sy[0], fifo_read_strobe_n};
      s_next.wr_sy = {s_reg.wr_sy[0], fifo_write_strobe_n};
      s_next.pk_sy = {s_reg.pk_sy[0], packet_commit_n};
      s_next.oe_sy = {s_reg.oe_sy[0], bus_drive_enable_n};
      s_next.sw_sy = {s_reg.sw_sy[0], socket_change_strobe_n};
      s_next.sel_sy = {s_reg.sel_sy[0], fifo_select_lines};
      s_next.dat_sy = {s_reg.dat_sy[0], data_in};
      s_next.rd_prev = rd_e;
      s_next.wr_prev = wr_e;
      s_next.pk_prev = pk_e;
      s_next.sw_prev = sw_e;
      if (!wr_e)
      begin
         s_next.d_hold = s_reg.dat_sy[1];
         s_next.pk_hold = !pk_e;
      end

      // Socket switching, 5-bit variant only
      case (s_reg.sw_state)
         SW_READY:
            if (sw_accept)
            begin
               s_next.sw_state = SW_WAIT;
               s_next.sw_cnt = SOCKET_SWITCH_LOAD;
               s_next.socket = sel_e[THREAD_W-1:0];
            end
         SW_WAIT:
            if (s_reg.sw_cnt == 7'h00)
               s_next.sw_state = SW_READY;
            else
               s_next.sw_cnt = s_reg.sw_cnt - 7'h01;
         default: s_next.sw_state = SW_READY;
      endcase
      if (!addr_5bit_mode)
         s_next.sw_state = SW_READY;
      s_next.cur_thread = addr_5bit_mode ? s_next.socket : sel_e[THREAD_W-1:0];
      s_next.atr = (s_next.sw_state == SW_READY) &&
         (thread_is_producer[s_next.cur_thread] ? f_in_ready[s_next.cur_thread] :
         f_out_valid[s_next.cur_thread]);

      // Data and flags: two stages after the thread register
      s_next.data_p1 = head_cur;
      s_next.data_out = s_reg.data_p1;
      s_next.oe_n = oe_e;
      s_next.flag_p1 = flag_raw;
      s_next.flag_out = s_reg.flag_p1;

      // Core words wait in a holding slot until their consumer FIFO has room;
      // words aimed at a producer thread are dropped instead of stalling
      if (s_reg.hold_v && (f_in_ready[s_reg.hold_t] || thread_is_producer[s_reg.hold_t]))
         s_next.hold_v = 1'b0;
      if (s_reg.tx_ready && core_tx_valid)
      begin
         s_next.hold_v = 1'b1;
         s_next.hold_t = core_tx_thread;
         s_next.hold_d = core_tx_data;
      end
      s_next.tx_ready = !s_next.hold_v;

      // Producer words out to the core, with their commit mark
      if (rx_take)
      begin
         s_next.rx_v = f_out_valid[core_rx_pick] && thread_is_producer[core_rx_pick];
         s_next.rx_t = core_rx_pick;
         s_next.rx_d = f_out_data[core_rx_pick][DATA_W-1:0];
         s_next.rx_last = f_out_data[core_rx_pick][DATA_W];
      end

      s_next.zlp_v = zlp_ev;
      if (zlp_ev)
         s_next.zlp_t = s_reg.cur_thread;
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         s_reg <= PORT_RESET;
      else
         s_reg <= s_next;
   end

   assign data_out = s_reg.data_out;
   assign data_oe_n = s_reg.oe_n;
   assign flag_a = s_reg.flag_out[0];
   assign flag_b = s_reg.flag_out[1];
   assign active_thread_ready = s_reg.atr;
   assign core_tx_ready = s_reg.tx_ready;
   assign core_rx_valid = s_reg.rx_v;
   assign core_rx_thread = s_reg.rx_t;
   assign core_rx_data = s_reg.rx_d;
   assign core_rx_last = s_reg.rx_last;
   assign zlp_valid = s_reg.zlp_v;
   assign zlp_thread = s_reg.zlp_t;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence s_sync_read;
      sync_mode && pop_ev;
   endsequence
   sequence s_sync_write;
      sync_mode && push_ev;
   endsequence
   sequence s_switch;
      sw_accept;
   endsequence

   property p_rd_latency;
      s_sync_read |-> ##2 (s_reg.data_out == $past(head_cur, 2));
   endproperty
   a_rd_latency: assert property (p_rd_latency) else $error("read data latency wrong");

   property p_rd_pop;
      (s_sync_read and (f_out_valid[s_reg.cur_thread] && !thread_is_producer[s_reg.cur_thread]
      && !f_in_valid[s_reg.cur_thread])) ##1 $stable(s_reg.cur_thread)
      |-> level_cur == $past(level_cur) - 3'h1;
   endproperty
   a_rd_pop: assert property (p_rd_pop) else $error("read did not pop");

   property p_flag_latency;
      s_sync_write |-> ##3 (s_reg.flag_out == $past(flag_raw, 2));
   endproperty
   a_flag_latency: assert property (p_flag_latency) else $error("flag latency wrong");

   property p_addr_latency;
      sync_mode && !addr_5bit_mode |=>
         (s_reg.cur_thread == $past(fifo_select_lines[THREAD_W-1:0]))
         ##2 (s_reg.data_out == $past(head_cur, 2));
   endproperty
   a_addr_latency: assert property (p_addr_latency) else $error("address latency wrong");

   property p_oe_only;
      sync_mode |=> (s_reg.oe_n == $past(bus_drive_enable_n));
   endproperty
   a_oe_only: assert property (p_oe_only) else $error("bus drive enable wrong");

   property p_ssd_min;
      s_switch |=> (!s_reg.atr) [*2];
   endproperty
   a_ssd_min: assert property (p_ssd_min) else $error("socket ready too early");

   property p_ssd_max;
      s_switch |-> ##[SSD_LO:SSD_HI] (s_reg.sw_state == SW_READY);
   endproperty
   a_ssd_max: assert property (p_ssd_max) else $error("socket switch too long");

   property p_wait_not_ready;
      s_reg.sw_state == SW_WAIT |-> !s_reg.atr;
   endproperty
   a_wait_not_ready: assert property (p_wait_not_ready) else $error("ready while switching");

   property p_no_ssd;
      !addr_5bit_mode |=> (s_reg.sw_state == SW_READY) &&
         (s_reg.cur_thread == $past(sel_e[THREAD_W-1:0]));
   endproperty
   a_no_ssd: assert property (p_no_ssd) else $error("2-bit variant delayed switch");

   property p_cs_ignore;
      cs_e |-> ((f_out_ready & ~thread_is_producer) == '0) &&
         ((f_in_valid & thread_is_producer) == '0) ##1 !s_reg.zlp_v;
   endproperty
   a_cs_ignore: assert property (p_cs_ignore) else $error("strobe taken while deselected");

   property p_zlp;
      zlp_ev |=> s_reg.zlp_v && (s_reg.zlp_t == $past(s_reg.cur_thread));
   endproperty
   a_zlp: assert property (p_zlp) else $error("zero-length packet lost");

   property p_async_wr;
      !sync_mode && !cs_e && $rose(wr_e) && thread_is_producer[s_reg.cur_thread] |->
         f_in_valid[s_reg.cur_thread] &&
         (f_in_data[s_reg.cur_thread][DATA_W-1:0] == s_reg.d_hold);
   endproperty
   a_async_wr: assert property (p_async_wr) else $error("async write not stored");

   property p_async_rd;
      !sync_mode && !cs_e && $rose(rd_e) && !thread_is_producer[s_reg.cur_thread] |->
         f_out_ready[s_reg.cur_thread];
   endproperty
   a_async_rd: assert property (p_async_rd) else $error("async read did not pop");
endmodule
`default_nettype wire

// ### verif/fifo_master.sv
// Behavioural external FIFO master driving the slave FIFO port pins
`default_nettype none
module fifo_master
   import sfifo_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Master pins
   output logic fifo_select_n,
   output logic bus_drive_enable_n,
   output logic fifo_read_strobe_n,
   output logic fifo_write_strobe_n,
   output logic packet_commit_n,
   output logic socket_change_strobe_n,
   output logic [ADDR_W-1:0] fifo_select_lines,
   output logic [DATA_W-1:0] data_in
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      {fifo_select_n, bus_drive_enable_n, fifo_read_strobe_n} = 3'h7;
      {fifo_write_strobe_n, packet_commit_n, socket_change_strobe_n} = 3'h7;
      fifo_select_lines = 5'h00;
      data_in = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Level pins move only between strobes, so the address is steady under them
   task automatic pins(input logic cs_n, input logic oe_n, input logic [ADDR_W-1:0] sel);
      @(negedge core_clk);
      fifo_select_n = cs_n;
      bus_drive_enable_n = oe_n;
      fifo_select_lines = sel;
   endtask

   // Packet end moves with the write strobe, never released before it
   task automatic step(input logic rd_n, input logic wr_n, input logic pk_n, input logic sw_n,
      input logic [DATA_W-1:0] d);
      @(negedge core_clk);
      fifo_read_strobe_n = rd_n;
      fifo_write_strobe_n = wr_n;
      packet_commit_n = pk_n;
      socket_change_strobe_n = sw_n;
      // A released bus keeps moving so a stale word can never pass for data
      data_in = wr_n ? ~data_in : d;
   endtask

   // Read strobe and bus enable wired together as one asynchronous signal
   task automatic tied_read(input logic lvl);
      @(negedge core_clk);
      fifo_read_strobe_n = lvl;
      bus_drive_enable_n = lvl;
   endtask
endmodule
`default_nettype wire

// ### verif/slave_fifo_port_tb.sv
// Self-checking testbench of the slave FIFO port
`default_nettype none
module slave_fifo_port_tb
   import sfifo_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic nrst, sync_mode, addr_5bit_mode, flag_a_current, flag_b_current;
   logic [THREADS-1:0] thread_is_producer;
   logic [1:0] flag_a_kind, flag_b_kind;
   logic [THREAD_W-1:0] flag_a_thread, flag_b_thread, core_tx_thread, core_rx_pick;
   wire logic fifo_select_n, bus_drive_enable_n, fifo_read_strobe_n, fifo_write_strobe_n;
   wire logic packet_commit_n, socket_change_strobe_n;
   wire logic [ADDR_W-1:0] fifo_select_lines;
   wire logic [DATA_W-1:0] data_in;
   logic [DATA_W-1:0] data_out, core_tx_data, core_rx_data;
   logic data_oe_n, flag_a, flag_b, active_thread_ready, core_tx_valid, core_tx_ready;
   logic core_rx_ready, core_rx_valid, core_rx_last, zlp_valid;
   logic [THREAD_W-1:0] core_rx_thread, zlp_thread;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   always #25 core_clk = ~core_clk;

   slave_fifo_port slave_fifo_port_inst (.core_clk, .nrst, .sync_mode, .addr_5bit_mode,
      .thread_is_producer, .flag_a_kind, .flag_a_current, .flag_a_thread, .flag_b_kind,
      .flag_b_current, .flag_b_thread, .fifo_select_n, .bus_drive_enable_n, .fifo_read_strobe_n,
      .fifo_write_strobe_n, .packet_commit_n, .socket_change_strobe_n, .fifo_select_lines,
      .data_in, .data_out, .data_oe_n, .flag_a, .flag_b, .active_thread_ready, .core_tx_valid,
      .core_tx_thread, .core_tx_data, .core_tx_ready, .core_rx_pick, .core_rx_ready,
      .core_rx_valid, .core_rx_thread, .core_rx_data, .core_rx_last, .zlp_valid, .zlp_thread);

   fifo_master fifo_master_inst (.core_clk, .fifo_select_n, .bus_drive_enable_n,
      .fifo_read_strobe_n, .fifo_write_strobe_n, .packet_commit_n, .socket_change_strobe_n,
      .fifo_select_lines, .data_in);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (n_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // Hangs end the run here rather than spinning forever
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         complete_run();
      end
   end

   task automatic do_reset();
      @(negedge core_clk);
      nrst = 1'b0;
      repeat (3) @(negedge core_clk);
      cmp_bit(data_oe_n, 1'b1);
      cmp_bit(active_thread_ready, 1'b0);
      nrst = 1'b1;
      repeat (3) @(negedge core_clk);
   endtask

   task automatic core_push(input logic [DATA_W-1:0] w);
      int n;
      n = 0;
      @(negedge core_clk);
      core_tx_valid = 1'b1;
      core_tx_data = w;
      while (core_tx_ready !== 1'b1 && n < 20)
      begin
         @(negedge core_clk);
         n++;
      end
      cmp_bit(core_tx_ready, 1'b1);
      @(negedge core_clk);
      cmp_bit(core_tx_ready, 1'b0);
      core_tx_valid = 1'b0;
   endtask

   // Drains a producer thread; a word too many or too few shows in the count
   task automatic drain(input logic [1:0] t, input logic [DATA_W-1:0] base, input int num,
      input int last_k);
      int k;
      k = 0;
      core_rx_pick = t;
      core_rx_ready = 1'b1;
      repeat (24)
      begin
         @(negedge core_clk);
         if (core_rx_valid === 1'b1)
         begin
            cmp_word(core_rx_data, base + DATA_W'(k));
            cmp_word(DATA_W'(core_rx_thread), DATA_W'(t));
            cmp_bit(core_rx_last, k == last_k);
            k++;
         end
      end
      core_rx_ready = 1'b0;
      core_rx_pick = 2'h2;
      cmp_word(DATA_W'(k), DATA_W'(num));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic write_burst();
      int k;
      fifo_master_inst.pins(1'b1, 1'b1, 5'h00);
      fifo_master_inst.step(1'b1, 1'b0, 1'b1, 1'b1, 16'h1fff);
      fifo_master_inst.step(1'b1, 1'b1, 1'b1, 1'b1, 16'h0000);
      fifo_master_inst.pins(1'b0, 1'b1, 5'h00);
      repeat (4) @(negedge core_clk);
      cmp_bit(active_thread_ready, 1'b1);
      for (k = 0; k < 9; k++)
      begin
         fifo_master_inst.step(1'b1, k > 3, k != 3, 1'b1, 16'h1000 + DATA_W'(k));
         cmp_bit(flag_b, k >= 4);
         cmp_bit(flag_a, k >= 6);
      end
      drain(2'h0, 16'h1000, 4, 3);
   endtask

   task automatic read_burst();
      int k;
      flag_b_kind = FLAG_EMPTY;
      for (k = 0; k < 3; k++)
         core_push(16'h2000 + DATA_W'(k));
      fifo_master_inst.pins(1'b0, 1'b0, 5'h02);
      for (k = 1; k < 5; k++)
      begin
         @(negedge core_clk);
         cmp_bit(flag_b, k < 3);
      end
      cmp_bit(data_oe_n, 1'b0);
      for (k = 0; k < 6; k++)
      begin
         fifo_master_inst.step(k > 2, 1'b1, 1'b1, 1'b1, 16'h0000);
         if (k < 5)
            cmp_word(data_out, 16'h2000 + DATA_W'(k > 2 ? k - 2 : 0));
      end
      repeat (3) @(negedge core_clk);
      cmp_bit(flag_b, 1'b1);
      fifo_master_inst.pins(1'b0, 1'b1, 5'h02);
      repeat (2) @(negedge core_clk);
      cmp_bit(data_oe_n, 1'b1);
      cmp_bit(flag_b, 1'b1);
   endtask

   task automatic zero_length();
      int k;
      int seen;
      seen = 0;
      fifo_master_inst.pins(1'b0, 1'b1, 5'h01);
      repeat (2) @(negedge core_clk);
      fifo_master_inst.step(1'b1, 1'b1, 1'b0, 1'b1, 16'h0000);
      fifo_master_inst.step(1'b1, 1'b1, 1'b1, 1'b1, 16'h0000);
      for (k = 0; k < 4; k++)
      begin
         if (zlp_valid === 1'b1)
         begin
            seen++;
            cmp_word(DATA_W'(zlp_thread), 16'h0001);
         end
         @(negedge core_clk);
      end
      cmp_word(DATA_W'(seen), 16'h0001);
   endtask

   task automatic socket_switch();
      int k;
      addr_5bit_mode = 1'b1;
      do_reset();
      fifo_master_inst.pins(1'b0, 1'b1, 5'h01);
      repeat (3) @(negedge core_clk);
      cmp_bit(active_thread_ready, 1'b1);
      fifo_master_inst.step(1'b1, 1'b1, 1'b1, 1'b0, 16'h0000);
      fifo_master_inst.step(1'b1, 1'b1, 1'b1, 1'b1, 16'h0000);
      for (k = 2; k < 10; k++)
      begin
         @(negedge core_clk);
         cmp_bit(active_thread_ready, k == 9);
      end
      fifo_master_inst.pins(1'b0, 1'b1, 5'h02);
      fifo_master_inst.step(1'b1, 1'b1, 1'b1, 1'b0, 16'h0000);
      fifo_master_inst.step(1'b1, 1'b1, 1'b1, 1'b1, 16'h0000);
      repeat (12) @(negedge core_clk);
      cmp_bit(active_thread_ready, 1'b0);
   endtask

   // Strobe levels last several clocks so the synchronisers see them
   task automatic async_write();
      {sync_mode, addr_5bit_mode} = 2'h0;
      do_reset();
      fifo_master_inst.pins(1'b0, 1'b1, 5'h01);
      repeat (3) @(negedge core_clk);
      fifo_master_inst.step(1'b1, 1'b0, 1'b1, 1'b1, 16'h3c3c);
      repeat (4) @(negedge core_clk);
      fifo_master_inst.step(1'b1, 1'b1, 1'b1, 1'b1, 16'h0000);
      drain(2'h1, 16'h3c3c, 1, -1);
   endtask

   // The word must show while the strobe is low and leave only on its rise
   task automatic async_read();
      core_push(16'h4a5b);
      fifo_master_inst.pins(1'b0, 1'b1, 5'h02);
      repeat (8) @(negedge core_clk);
      fifo_master_inst.tied_read(1'b0);
      repeat (8) @(negedge core_clk);
      cmp_bit(data_oe_n, 1'b0);
      cmp_word(data_out, 16'h4a5b);
      cmp_bit(flag_b, 1'b0);
      fifo_master_inst.tied_read(1'b1);
      repeat (8) @(negedge core_clk);
      cmp_bit(data_oe_n, 1'b1);
      cmp_bit(flag_b, 1'b1);
   endtask

   initial
   begin
      {nrst, sync_mode, addr_5bit_mode, flag_a_current, flag_b_current} = 5'h09;
      thread_is_producer = 4'h3;
      {flag_a_kind, flag_b_kind} = {FLAG_FULL, FLAG_PARTIAL};
      {flag_a_thread, flag_b_thread} = 4'h0;
      {core_tx_valid, core_rx_ready} = 2'h0;
      {core_tx_thread, core_rx_pick} = 4'ha;
      core_tx_data = 16'h0000;
      do_reset();
      write_burst();
      read_burst();
      zero_length();
      socket_switch();
      async_write();
      async_read();
      complete_run();
   end
endmodule
`default_nettype wire
